// *** core/rps_pin_select.sv ***
// Remappable pin select crossbar: per-pin output routing, per-input routing.
// Assumes pads and peripherals are synchronous to clk; fields load by index.
`default_nettype none

module rps_pin_select
  import rps_pkg::*;
#(
  parameter bit HasCan   = 1'b1,
  parameter bit HasMotor = 1'b1
) (
  // Clock and reset
  input  wire logic                               clk,
  input  wire logic                               rst,
  // Output field load
  input  wire logic                               outWrEn,
  input  wire logic [rps_pkg::OUT_IDX_W-1:0]      outWrIdx,
  input  wire logic [rps_pkg::OUT_CODE_W-1:0]     outWrCode,
  // Input field load
  input  wire logic                               inWrEn,
  input  wire logic [rps_pkg::IN_IDX_W-1:0]       inWrIdx,
  input  wire logic [rps_pkg::IN_CODE_W-1:0]      inWrCode,
  // Field state
  output logic      [rps_pkg::OUT_CODE_W-1:0]     pinOutputRouteRegs [rps_pkg::NUM_OUT_PINS],
  output logic      [rps_pkg::IN_CODE_W-1:0]      peripheralInputRouteRegs [rps_pkg::NUM_PERIPH_IN],
  // Peripheral outputs
  input  wire logic                               serialPortATransmit,
  input  wire logic                               serialPortBTransmit,
  input  wire logic                               spiBDataOut,
  input  wire logic                               spiBClockOut,
  input  wire logic                               spiBSelectOut,
  input  wire logic                               canTransmit,
  input  wire logic [rps_pkg::NUM_OCMP-1:0]       compareUnitOut,
  input  wire logic [rps_pkg::NUM_CMP-1:0]        comparatorOut,
  input  wire logic                               pwmTimebaseSyncOut,
  input  wire logic                               encoderCountCompareOut,
  input  wire logic                               referenceClockOut,
  // Peripheral inputs
  output logic      [rps_pkg::NUM_PERIPH_IN-1:0]  periphIn,
  // Pads: input buffers
  input  wire logic [rps_pkg::NUM_PAD_IN-1:0]     padIn,
  // Pads: default port function
  input  wire logic [rps_pkg::NUM_OUT_PINS-1:0]   portOut,
  input  wire logic [rps_pkg::NUM_OUT_PINS-1:0]   portOe,
  // Pads: output drivers
  output logic      [rps_pkg::NUM_OUT_PINS-1:0]   pinOut,
  output logic      [rps_pkg::NUM_OUT_PINS-1:0]   pinOe,
  output logic      [rps_pkg::NUM_OUT_PINS-1:0]   pinRemapped
);

  logic [OUT_CODE_W-1:0]    next_pinOutputRouteRegs [NUM_OUT_PINS];
  logic [IN_CODE_W-1:0]     next_peripheralInputRouteRegs [NUM_PERIPH_IN];
  logic [NUM_PERIPH_IN-1:0] next_periphIn;
  logic [NUM_OUT_PINS-1:0]  next_pinOut;
  logic [NUM_OUT_PINS-1:0]  next_pinOe;
  logic [NUM_OUT_PINS-1:0]  next_pinRemapped;
  logic [NUM_OUT_PINS-1:0]  selDrive;
  logic [NUM_OUT_PINS-1:0]  selRemapped;
  logic [NUM_OUT_SRC-1:0]   srcVec;
  logic [NUM_OUT_SRC-1:0]   srcValid;

  // Peripheral outputs laid out by code; variant gating kept in the valid mask
  always_comb begin
    srcVec                   = '0;
    srcVec[OUT_SERIAL_A_TX]  = serialPortATransmit;
    srcVec[OUT_SERIAL_B_TX]  = serialPortBTransmit;
    srcVec[OUT_SPI_B_DATA]   = spiBDataOut;
    srcVec[OUT_SPI_B_CLOCK]  = spiBClockOut;
    srcVec[OUT_SPI_B_SELECT] = spiBSelectOut;
    srcVec[OUT_CAN_TX]       = canTransmit;
    for (int i = 0; i < NUM_OCMP; i++) begin
      srcVec[OUT_COMPARE_A + 6'(i)] = compareUnitOut[i];
    end
    for (int i = 0; i < NUM_CMP - 1; i++) begin
      srcVec[OUT_COMPARATOR_A + 6'(i)] = comparatorOut[i];
    end
    srcVec[OUT_COMPARATOR_D] = comparatorOut[NUM_CMP-1];
    srcVec[OUT_PWM_SYNC]     = pwmTimebaseSyncOut;
    srcVec[OUT_ENC_COMPARE]  = encoderCountCompareOut;
    srcVec[OUT_REF_CLOCK]    = referenceClockOut;
  end

  // Which codes exist on this variant; the rest fall back to the port
  always_comb begin
    srcValid                   = '0;
    srcValid[OUT_SERIAL_A_TX]  = 1'b1;
    srcValid[OUT_SERIAL_B_TX]  = 1'b1;
    srcValid[OUT_SPI_B_DATA]   = 1'b1;
    srcValid[OUT_SPI_B_CLOCK]  = 1'b1;
    srcValid[OUT_SPI_B_SELECT] = 1'b1;
    srcValid[OUT_CAN_TX]       = HasCan;
    for (int i = 0; i < NUM_OCMP; i++) begin
      srcValid[OUT_COMPARE_A + 6'(i)] = 1'b1;
    end
    for (int i = 0; i < NUM_CMP - 1; i++) begin
      srcValid[OUT_COMPARATOR_A + 6'(i)] = 1'b1;
    end
    srcValid[OUT_COMPARATOR_D] = 1'b1;
    srcValid[OUT_PWM_SYNC]     = HasMotor;
    srcValid[OUT_ENC_COMPARE]  = HasMotor;
    srcValid[OUT_REF_CLOCK]    = 1'b1;
  end

  // Field loads: no cross-checks, any combination is stored as given
  always_comb begin
    for (int p = 0; p < NUM_OUT_PINS; p++) begin
      next_pinOutputRouteRegs[p] = pinOutputRouteRegs[p];
      if (outWrEn && outWrIdx == OUT_IDX_W'(p)) begin
        next_pinOutputRouteRegs[p] = outWrCode;
      end
    end
    for (int k = 0; k < NUM_PERIPH_IN; k++) begin
      next_peripheralInputRouteRegs[k] = peripheralInputRouteRegs[k];
      if (inWrEn && inWrIdx == IN_IDX_W'(k)) begin
        next_peripheralInputRouteRegs[k] = inWrCode;
      end
    end
  end

  // Field storage; reset parks every output field on the null code
  always_ff @(posedge clk) begin
    for (int p = 0; p < NUM_OUT_PINS; p++) begin
      pinOutputRouteRegs[p] <= rst ? OUT_CODE_RST : next_pinOutputRouteRegs[p];
    end
    for (int k = 0; k < NUM_PERIPH_IN; k++) begin
      peripheralInputRouteRegs[k] <= rst ? IN_CODE_RST : next_peripheralInputRouteRegs[k];
    end
  end

  // Per-pin selectors look at the next field value so a load lands in one edge
  generate
    for (genvar p = 0; p < NUM_OUT_PINS; p++) begin : gOutSel
      rps_out_select uSel (
        .code     (next_pinOutputRouteRegs[p]),
        .srcVec   (srcVec),
        .srcValid (srcValid),
        .drive    (selDrive[p]),
        .remapped (selRemapped[p])
      );
    end
  endgenerate

  // Pad drive: remapped peripheral wins, otherwise the port function
  always_comb begin
    for (int p = 0; p < NUM_OUT_PINS; p++) begin
      next_pinRemapped[p] = selRemapped[p];
      next_pinOut[p]      = selRemapped[p] ? selDrive[p] : portOut[p];
      next_pinOe[p]       = selRemapped[p] | portOe[p];
    end
  end

  // Peripheral inputs: same decode per input, a pad may feed several
  always_comb begin
    for (int k = 0; k < NUM_PERIPH_IN; k++) begin
      next_periphIn[k] = in_route(next_peripheralInputRouteRegs[k], comparatorOut,
                                  padIn);
    end
  end

  // Registered pad and peripheral side; a flop per pin keeps unchanged pins glitch free
  always_ff @(posedge clk) begin
    if (rst) begin
      pinRemapped <= '0;
      pinOut      <= '0;
      pinOe       <= '0;
      periphIn    <= '0;
    end else begin
      pinRemapped <= next_pinRemapped;
      pinOut      <= next_pinOut;
      pinOe       <= next_pinOe;
      periphIn    <= next_periphIn;
    end
  end

  // Checks below compare registered outputs with the current field value
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // Index 3 stores nothing, so only loads aimed at a real pin are followed
  sequence s_outLoad;
    (outWrEn && outWrIdx < OUT_IDX_W'(NUM_OUT_PINS)) ##1 1'b1;
  endsequence

  a_reset_disconnect: assert property (
    disable iff (1'b0) rst |=> (pinRemapped == '0))
    else $error("remapped output present after reset");

  a_field_load: assert property (
    s_outLoad |-> pinOutputRouteRegs[$past(outWrIdx)] == $past(outWrCode))
    else $error("output field not stored as written");

  a_in_load: assert property (
    inWrEn |=> peripheralInputRouteRegs[$past(inWrIdx)] == $past(inWrCode))
    else $error("input field not stored as written");

  generate
    for (genvar p = 0; p < NUM_OUT_PINS; p++) begin : gPinChk
      // Reset parks pinOut low for one edge before the port level shows
      a_zero_default: assert property (
        !$past(rst) && pinOutputRouteRegs[p] == OUT_DEFAULT |->
          !pinRemapped[p] && pinOut[p] == $past(portOut[p]))
        else $error("null code did not give the port function");

      a_serial_route: assert property (
        pinOutputRouteRegs[p] == OUT_SERIAL_B_TX |->
          pinRemapped[p] && pinOut[p] == $past(serialPortBTransmit))
        else $error("serial port B transmit not routed");

      a_spi_route: assert property (
        pinOutputRouteRegs[p] == OUT_SPI_B_CLOCK |->
          pinOe[p] && pinOut[p] == $past(spiBClockOut))
        else $error("SPI B clock not routed");

      a_compare_route: assert property (
        pinOutputRouteRegs[p] == OUT_COMPARE_A + 6'h03 |->
          pinOut[p] == $past(compareUnitOut[3]))
        else $error("compare unit D not routed");

      a_cmp_d_route: assert property (
        pinOutputRouteRegs[p] == OUT_COMPARATOR_D |->
          pinOut[p] == $past(comparatorOut[3]))
        else $error("comparator D not routed");

      a_refclk_route: assert property (
        pinOutputRouteRegs[p] == OUT_REF_CLOCK |->
          pinOut[p] == $past(referenceClockOut))
        else $error("reference clock not routed");

      a_serial_a_route: assert property (
        pinOutputRouteRegs[p] == OUT_SERIAL_A_TX |->
          pinRemapped[p] && pinOut[p] == $past(serialPortATransmit))
        else $error("serial port A transmit not routed");

      a_spi_data_route: assert property (
        pinOutputRouteRegs[p] == OUT_SPI_B_DATA |->
          pinRemapped[p] && pinOut[p] == $past(spiBDataOut))
        else $error("SPI B data not routed");

      a_spi_select_route: assert property (
        pinOutputRouteRegs[p] == OUT_SPI_B_SELECT |->
          pinRemapped[p] && pinOut[p] == $past(spiBSelectOut))
        else $error("SPI B select not routed");

      // Variant-gated codes fall back to the port when the unit is absent
      a_can_route: assert property (
        pinOutputRouteRegs[p] == OUT_CAN_TX |-> pinRemapped[p] == HasCan &&
          (!HasCan || pinOut[p] == $past(canTransmit)))
        else $error("CAN transmit routing wrong for variant");

      a_sync_route: assert property (
        pinOutputRouteRegs[p] == OUT_PWM_SYNC |-> pinRemapped[p] == HasMotor &&
          (!HasMotor || pinOut[p] == $past(pwmTimebaseSyncOut)))
        else $error("PWM sync routing wrong for variant");

      a_cmp_a_route: assert property (
        pinOutputRouteRegs[p] == OUT_COMPARATOR_A |->
          pinRemapped[p] && pinOut[p] == $past(comparatorOut[0]))
        else $error("comparator A not routed");

      a_port_oe: assert property (
        !$past(rst) && !pinRemapped[p] |-> pinOe[p] == $past(portOe[p]))
        else $error("port enable not passed through");

      a_unassigned_idle: assert property (
        !srcValid[pinOutputRouteRegs[p]] |-> !pinRemapped[p])
        else $error("unassigned code drove a pin");

      a_untouched_hold: assert property (
        !(outWrEn && outWrIdx == OUT_IDX_W'(p)) ##1 !outWrEn |=>
          $stable(pinOutputRouteRegs[p]))
        else $error("untouched field changed");
    end
  endgenerate

  generate
    for (genvar k = 0; k < NUM_PERIPH_IN; k++) begin : gInChk
      a_in_ground: assert property (
        peripheralInputRouteRegs[k] == IN_GROUND |-> !periphIn[k])
        else $error("ground code did not tie input low");

      a_in_pin97: assert property (
        peripheralInputRouteRegs[k] == IN_PIN_97 |->
          periphIn[k] == $past(padIn[PAD_PIN_97]))
        else $error("pin 97 not routed to input");

      a_in_pin121: assert property (
        peripheralInputRouteRegs[k] == IN_PIN_121 |->
          periphIn[k] == $past(padIn[NUM_PAD_IN-1]))
        else $error("pin 121 not routed to input");

      a_in_cmp: assert property (
        peripheralInputRouteRegs[k] == IN_COMPARATOR_A |->
          periphIn[k] == $past(comparatorOut[0]))
        else $error("comparator A not routed to input");
    end
  endgenerate

  a_fanout_same: assert property (
    pinOutputRouteRegs[0] == pinOutputRouteRegs[1] |->
      pinOut[0] == pinOut[1] || !pinRemapped[0])
    else $error("shared source gave different pin levels");

endmodule // rps_pin_select

`default_nettype wire

// *** pkg/rps_pkg.sv ***
// Constants, codes and decode helpers for the remappable pin select crossbar.
// Assumes one system clock and a synchronous active-high reset in every user.
`default_nettype none

package rps_pkg;

  // Field widths and crossbar dimensions
  localparam int OUT_CODE_W    = 6;
  localparam int IN_CODE_W     = 7;
  localparam int NUM_OUT_SRC   = 64;
  localparam int NUM_OUT_PINS  = 3;
  localparam int NUM_PAD_IN    = 8;
  localparam int NUM_PERIPH_IN = 4;
  localparam int NUM_CMP       = 4;
  localparam int NUM_OCMP      = 4;
  localparam int OUT_IDX_W     = $clog2(NUM_OUT_PINS);
  localparam int IN_IDX_W      = $clog2(NUM_PERIPH_IN);

  // Values after reset
  localparam logic [OUT_CODE_W-1:0] OUT_CODE_RST = 6'h00;
  localparam logic [IN_CODE_W-1:0]  IN_CODE_RST  = 7'h00;

  // Output selection codes, one per peripheral output
  localparam logic [OUT_CODE_W-1:0] OUT_DEFAULT      = 6'h00;
  localparam logic [OUT_CODE_W-1:0] OUT_SERIAL_A_TX  = 6'h01;
  localparam logic [OUT_CODE_W-1:0] OUT_SERIAL_B_TX  = 6'h03;
  localparam logic [OUT_CODE_W-1:0] OUT_SPI_B_DATA   = 6'h08;
  localparam logic [OUT_CODE_W-1:0] OUT_SPI_B_CLOCK  = 6'h09;
  localparam logic [OUT_CODE_W-1:0] OUT_SPI_B_SELECT = 6'h0a;
  localparam logic [OUT_CODE_W-1:0] OUT_CAN_TX       = 6'h0e;
  localparam logic [OUT_CODE_W-1:0] OUT_COMPARE_A    = 6'h10;
  localparam logic [OUT_CODE_W-1:0] OUT_COMPARATOR_A = 6'h18;
  localparam logic [OUT_CODE_W-1:0] OUT_PWM_SYNC     = 6'h2d;
  localparam logic [OUT_CODE_W-1:0] OUT_ENC_COMPARE  = 6'h2f;
  localparam logic [OUT_CODE_W-1:0] OUT_REF_CLOCK    = 6'h31;
  localparam logic [OUT_CODE_W-1:0] OUT_COMPARATOR_D = 6'h32;

  // Input selection codes
  localparam logic [IN_CODE_W-1:0] IN_GROUND       = 7'h00;
  localparam logic [IN_CODE_W-1:0] IN_COMPARATOR_A = 7'h01;
  localparam logic [IN_CODE_W-1:0] IN_PIN_94       = 7'h5e;
  localparam logic [IN_CODE_W-1:0] IN_PIN_97       = 7'h61;
  localparam logic [IN_CODE_W-1:0] IN_PIN_118      = 7'h76;
  localparam logic [IN_CODE_W-1:0] IN_PIN_121      = 7'h79;

  // Pad input order: pins 94,95,96,97 then 118,119,120,121
  localparam int PAD_LOW_BASE  = 0;
  localparam int PAD_HIGH_BASE = 4;
  localparam int PAD_PIN_97    = 3;

  // Output pin order: bidirectional pins 97, 118, 120
  localparam int OUT_PIN_97  = 0;
  localparam int OUT_PIN_118 = 1;
  localparam int OUT_PIN_120 = 2;

  // Peripheral input source for one selection code; unassigned codes give 0
  function automatic logic in_route(input logic [IN_CODE_W-1:0]  code,
                                    input logic [NUM_CMP-1:0]    cmp,
                                    input logic [NUM_PAD_IN-1:0] pad);
    logic res;
    res = 1'b0;
    if (code >= IN_COMPARATOR_A && code < IN_COMPARATOR_A + 7'(NUM_CMP)) begin
      res = cmp[2'(code - IN_COMPARATOR_A)];
    end else if (code >= IN_PIN_94 && code <= IN_PIN_97) begin
      res = pad[PAD_LOW_BASE + int'(code - IN_PIN_94)];
    end else if (code >= IN_PIN_118 && code <= IN_PIN_121) begin
      res = pad[PAD_HIGH_BASE + int'(code - IN_PIN_118)];
    end
    return res;
  endfunction

endpackage

`default_nettype wire

// *** core/rps_out_select.sv ***
// One pin's output selector: picks the peripheral output named by the code.
// Assumes the source and valid vectors are indexed by output selection code.
`default_nettype none

module rps_out_select
  import rps_pkg::*;
(
  // Selection
  input  wire logic [rps_pkg::OUT_CODE_W-1:0]  code,
  // Peripheral outputs and which codes exist
  input  wire logic [rps_pkg::NUM_OUT_SRC-1:0] srcVec,
  input  wire logic [rps_pkg::NUM_OUT_SRC-1:0] srcValid,
  // Result
  output logic                                 drive,
  output logic                                 remapped
);

  // Zero and unassigned codes leave the pin to its port function
  always_comb begin
    remapped = (code != OUT_DEFAULT) && srcValid[code];
    drive    = remapped && srcVec[code];
  end

endmodule // rps_out_select

`default_nettype wire

// *** testbench/rps_periph_model.sv ***
// Model of the peripherals and pads around the pin select crossbar.
// Assumes the bench clock; every level moves 1 ns after a rising edge.
`default_nettype none

module rps_periph_model (
  // Clock
  input  wire logic        clk,
  // Peripheral outputs, pad inputs and port function, as one vector
  output logic      [30:0] srcs
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [31:0] lfsr = 32'h0000_0001;

  // Shift register, so that no two sources track each other for long
  always @(posedge clk) begin
    lfsr <= #1 {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
  end

  assign srcs = lfsr[30:0];
endmodule // rps_periph_model

`default_nettype wire

// *** testbench/remappable_pin_select_test.sv ***
// Self-checking bench for the remappable pin select crossbar.
// Assumes the partner model drives all peripheral, pad and port levels.
`default_nettype none

module remappable_pin_select_test
  import rps_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic                  clk = 1'b0;
  logic                  rst = 1'b1;
  logic                  outWrEn = 1'b0;
  logic [OUT_IDX_W-1:0]  outWrIdx = '0;
  logic [OUT_CODE_W-1:0] outWrCode = '0;
  logic                  inWrEn = 1'b0;
  logic [IN_IDX_W-1:0]   inWrIdx = '0;
  logic [IN_CODE_W-1:0]  inWrCode = '0;
  logic [OUT_CODE_W-1:0] pinOutputRouteRegs [NUM_OUT_PINS];
  logic [IN_CODE_W-1:0]  peripheralInputRouteRegs [NUM_PERIPH_IN];
  logic [3:0]            periphIn;
  logic [2:0]            pinOut;
  logic [2:0]            pinOe;
  logic [2:0]            pinRemapped;
  wire logic [30:0]      srcs;
  logic [30:0]           prevSrc;
  int                    error_cnt = 0;
  int                    compares = 0;
  int                    cycles = 0;

  always #50 clk = ~clk;

  // Sources as the crossbar sampled them at the last edge
  always @(posedge clk) prevSrc <= srcs;

  rps_periph_model partner (.clk(clk), .srcs(srcs));

  rps_pin_select dut (
    .clk(clk), .rst(rst),
    .outWrEn(outWrEn), .outWrIdx(outWrIdx), .outWrCode(outWrCode),
    .inWrEn(inWrEn), .inWrIdx(inWrIdx), .inWrCode(inWrCode),
    .pinOutputRouteRegs(pinOutputRouteRegs),
    .peripheralInputRouteRegs(peripheralInputRouteRegs),
    .serialPortATransmit(srcs[0]), .serialPortBTransmit(srcs[1]),
    .spiBDataOut(srcs[2]), .spiBClockOut(srcs[3]), .spiBSelectOut(srcs[4]),
    .canTransmit(srcs[5]), .compareUnitOut(srcs[9:6]), .comparatorOut(srcs[13:10]),
    .pwmTimebaseSyncOut(srcs[14]), .encoderCountCompareOut(srcs[15]),
    .referenceClockOut(srcs[16]), .periphIn(periphIn), .padIn(srcs[24:17]),
    .portOut(srcs[27:25]), .portOe(srcs[30:28]),
    .pinOut(pinOut), .pinOe(pinOe), .pinRemapped(pinRemapped)
  );

  // Remapped flag and carried level for one output code
  function automatic logic [1:0] exp_out(input logic [5:0] c, input logic [30:0] s);
    case (c)
      6'h01: return {1'b1, s[0]};
      6'h03: return {1'b1, s[1]};
      6'h08: return {1'b1, s[2]};
      6'h09: return {1'b1, s[3]};
      6'h0a: return {1'b1, s[4]};
      6'h0e: return {1'b1, s[5]};
      6'h10, 6'h11, 6'h12, 6'h13: return {1'b1, s[6 + c[1:0]]};
      6'h18, 6'h19, 6'h1a: return {1'b1, s[10 + c[1:0]]};
      6'h32: return {1'b1, s[13]};
      6'h2d: return {1'b1, s[14]};
      6'h2f: return {1'b1, s[15]};
      6'h31: return {1'b1, s[16]};
      default: return 2'b00;
    endcase
  endfunction

  // Level a peripheral input should see for one input code
  function automatic logic exp_in(input logic [6:0] c, input logic [30:0] s);
    if (c >= 7'h01 && c <= 7'h04) return s[9 + c];
    if (c >= 7'h5e && c <= 7'h61) return s[17 + c - 7'h5e];
    if (c >= 7'h76 && c <= 7'h79) return s[21 + c - 7'h76];
    return 1'b0;
  endfunction

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One pin against the routing its field should give
  task automatic chk_pin(input int i, input logic [5:0] c);
    logic [1:0] e;
    e = exp_out(c, prevSrc);
    check("pinRemapped", pinRemapped[i], e[1]);
    check("pinOut", pinOut[i], e[1] ? e[0] : prevSrc[25 + i]);
    check("pinOe", pinOe[i], e[1] | prevSrc[28 + i]);
    check("outField", pinOutputRouteRegs[i], c);
  endtask

  task automatic load_out(input logic [1:0] idx, input logic [5:0] c);
    @(posedge clk);
    #1 outWrEn = 1'b1;
    outWrIdx = idx;
    outWrCode = c;
    @(posedge clk);
    #1 outWrEn = 1'b0;
  endtask

  task automatic load_in(input logic [1:0] idx, input logic [6:0] c);
    @(posedge clk);
    #1 inWrEn = 1'b1;
    inWrIdx = idx;
    inWrCode = c;
    @(posedge clk);
    #1 inWrEn = 1'b0;
  endtask

  // Reset held five cycles clears every field and disconnects every pin
  task automatic do_reset();
    @(posedge clk);
    #1 rst = 1'b1;
    repeat (5) @(posedge clk);
    #1;
    for (int i = 0; i < 4; i++) check("inField", peripheralInputRouteRegs[i], 8'h00);
    check("periphIn", periphIn, 8'h00);
    check("pinRemapped", pinRemapped, 8'h00);
    rst = 1'b0;
    @(posedge clk);
    #1;
    for (int i = 0; i < 3; i++) chk_pin(i, 6'h00);
  endtask

  // Every output code on one pin; the other pins must not move
  task automatic t_out_codes();
    for (int c = 0; c < 64; c++) begin
      load_out(2'd1, 6'(c));
      chk_pin(1, 6'(c));
      @(posedge clk);
      #1 chk_pin(1, 6'(c));
      chk_pin(0, 6'h00);
      chk_pin(2, 6'h00);
    end
  endtask

  // One source on all pins, then back-to-back loads on a single pin
  task automatic t_fanout();
    logic [5:0] seq [4];
    seq = '{6'h01, 6'h03, 6'h09, 6'h18};
    for (int i = 0; i < 3; i++) load_out(2'(i), 6'h31);
    load_out(2'd3, 6'h01);
    for (int i = 0; i < 3; i++) chk_pin(i, 6'h31);
    @(posedge clk);
    #1 outWrEn = 1'b1;
    outWrIdx = 2'd0;
    for (int k = 0; k < 4; k++) begin
      outWrCode = seq[k];
      @(posedge clk);
      #1 chk_pin(0, seq[k]);
      chk_pin(1, 6'h31);
      chk_pin(2, 6'h31);
    end
    outWrEn = 1'b0;
  endtask

  // Every input code on one input, then one pad feeding all inputs
  task automatic t_in_codes();
    for (int c = 0; c < 128; c++) begin
      load_in(2'd2, 7'(c));
      check("inField", peripheralInputRouteRegs[2], 8'(c));
      check("periphIn", periphIn[2], exp_in(7'(c), prevSrc));
    end
    for (int i = 0; i < 4; i++) load_in(2'(i), 7'h61);
    @(posedge clk);
    #1;
    for (int i = 0; i < 4; i++) check("periphIn", periphIn[i], prevSrc[20]);
  endtask

  task automatic report_and_stop();
    if (error_cnt == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Cuts a hang short; the whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      error_cnt++;
      report_and_stop();
    end
  end

  initial begin
    do_reset();
    t_out_codes();
    t_fanout();
    t_in_codes();
    do_reset();
    report_and_stop();
  end
endmodule // remappable_pin_select_test

`default_nettype wire
